/* File: verilog/qact_map.svh */
`ifndef QACT_MAP_SVH
`define QACT_MAP_SVH

// Converter geometry.
`define QACT_CHANNELS 4
`define QACT_WORD_BITS 16
`define QACT_LP_BITS 14
// Pipeline depth from the sampling edge to the output word.
`define QACT_LATENCY 16
// Output FIFO depth in words.
`define QACT_FIFO_DEPTH 16
// Clamp pattern: one cycle high, then two cycles low.
`define QACT_CLAMP_HIGH 2'h1
`define QACT_CLAMP_LOW 2'h2
`define QACT_CLAMP_PERIOD 2'h3
// Serial bit index of the first (most significant) bit sent.
`define QACT_SER_FIRST 4'hf

`endif

/* File: verilog/qact_pkg.sv */
package qact_pkg;

    // One sample code of one channel.
    typedef logic [15:0] qact_code_t;

    // One sampled frame of all four channels with its capture mode.
    typedef struct packed {
        qact_code_t [3:0] code;
        logic low_power;
        logic valid;
    } qact_stage_s;

    // Output coding format.
    typedef enum logic {
        QACT_OFFSET_BIN,
        QACT_TWOS_COMP
    } qact_format_e;

    // Serial output sequencer states.
    typedef enum logic {
        QACT_SER_IDLE,
        QACT_SER_SHIFT
    } qact_ser_state_e;

endpackage

/* File: verilog/qact_fifo.sv */
`timescale 1ns/100ps
`default_nettype none

// Synchronous FIFO with valid/ready on both sides.
module qact_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] count_q;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    // Full and empty come straight from the occupancy count.
    assign in_ready = (count_q != (AW+1)'(DEPTH));
    assign out_valid = (count_q != '0);
    assign out_data = mem[rd_q];

    // Storage array written on push only; no reset needed for data.
    always_ff @(posedge clk_sys)
    begin
        if (push)
            mem[wr_q] <= in_data;
    end

    // Pointers and occupancy.
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            wr_q <= '0;
            rd_q <= '0;
            count_q <= '0;
        end
        else
        begin
            if (push)
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            if (pop)
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

`default_nettype wire

/* File: verilog/qact_top.sv */
// Function
// RQ1: A new sample of every channel is taken on each rising edge of the converter clock.
// RQ2: Each sample moves one pipeline stage per edge and its word appears exactly 16 cycles after it was taken.
// RQ3: Words leave as 16-bit serial words coded as offset binary or two's complement as configured.
// RQ4: Low-power mode powers down the high-resolution front end and runs all four channels as 14-bit converters.
// RQ5: The resolution mode may change at any time without a reset and takes effect on the next sample.
// RQ6: High-resolution mode converts the hi_res_input set and low-power mode the low_power_input set.
// RQ7: Clamping acts only on the 14-bit inputs and never on the 16-bit inputs.
// RQ8: The controlling party sets dc_restore_enable to clamp, and with it clear no clamping happens.
// RQ9: The external timing logic pulses frame_align_in high so the clamp phase meets the sensor reset phase.
// RQ10: After alignment the clamp control is high one cycle and low two cycles, repeating.
// RQ11: Every frame_align_in pulse restarts the pattern at its high phase, and a clear enable keeps clamp low; the code ignores pulses shorter than two cycles.
`include "qact_map.svh"
`timescale 1ns/100ps
`default_nettype none

module qact_top (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Digitised front-end codes
    input wire logic [63:0] hi_res_input,
    input wire logic [55:0] low_power_input,
    // Configuration
    input wire logic low_power_mode,
    input wire logic twos_comp_format,
    input wire logic dc_restore_enable,
    // Clamp alignment pin
    input wire logic frame_align_in,
    // Analog controls
    output logic hi_res_frontend_pd,
    output logic clamp_low_power_path,
    output logic clamp_hi_res_path,
    // Parallel pipeline output
    output qact_pkg::qact_stage_s pipe_word,
    // Serial outputs and receiver ready
    output logic [3:0] serial_data,
    output logic serial_frame,
    input wire logic serial_ready,
    // Buffer status
    output logic fifo_in_ready,
    output logic fifo_overflow
);
    localparam int LAT = `QACT_LATENCY;

    // Sample capture and formatting.
    qact_pkg::qact_stage_s sample_now;
    qact_pkg::qact_stage_s pipe_q [LAT];
    qact_pkg::qact_format_e fmt;
    logic [63:0] fifo_out;
    logic fifo_out_valid;
    logic fifo_pop;

    assign fmt = twos_comp_format ? qact_pkg::QACT_TWOS_COMP : qact_pkg::QACT_OFFSET_BIN;

    // Per-channel selection, 14-bit left justification and coding.
    genvar ch;
    generate
        for (ch = 0; ch < `QACT_CHANNELS; ch++)
        begin : g_ch
            wire [15:0] hi_code = hi_res_input[ch*16 +: 16];
            wire [15:0] lp_code = {low_power_input[ch*14 +: 14], 2'h0};
            wire [15:0] raw = low_power_mode ? lp_code : hi_code; // RQ6 RQ4
            wire flip = (fmt == qact_pkg::QACT_TWOS_COMP);
            assign sample_now.code[ch] = {raw[15] ^ flip, raw[14:0]}; // RQ3
        end
    endgenerate
    assign sample_now.low_power = low_power_mode; // RQ5
    assign sample_now.valid = 1'b1; // RQ1

    // The mode travels with each sample, so switching never needs a reset.
    assign hi_res_frontend_pd = low_power_mode; // RQ4 RQ5

    // Latency pipeline: stage 0 captures, stage LAT-1 is the output word.
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            pipe_q[0] <= '0;
        else
            pipe_q[0] <= sample_now; // RQ1
    end

    genvar st;
    generate
        for (st = 1; st < LAT; st++)
        begin : g_pipe
            always_ff @(posedge clk_sys)
            begin
                if (reset)
                    pipe_q[st] <= '0;
                else
                    pipe_q[st] <= pipe_q[st-1]; // RQ2
            end
        end
    endgenerate
    assign pipe_word = pipe_q[LAT-1]; // RQ2

    // Frame alignment pin: three-stage synchroniser, change counted on agreement.
    logic [2:0] align_sync_q;
    logic align_level_q;
    wire align_agree = (align_sync_q[1] == align_sync_q[2]);
    wire align_rise = align_agree && align_sync_q[2] && !align_level_q;

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            align_sync_q <= 3'h0;
        else
            align_sync_q <= {align_sync_q[1:0], frame_align_in};
    end

    // Filtered level of the alignment pin.
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            align_level_q <= 1'b0;
        else if (align_agree)
            align_level_q <= align_sync_q[2];
    end

    // Clamp phase counter: phase 0 is the high cycle, phases 1 and 2 are low.
    logic [1:0] phase_q;
    logic [1:0] phase_d;
    logic aligned_q;
    logic clamp_q;
    wire phase_wrap = (phase_q == `QACT_CLAMP_PERIOD - 2'h1);

    assign phase_d = align_rise ? 2'h0 : (phase_wrap ? 2'h0 : phase_q + 2'h1); // RQ11 RQ9

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            phase_q <= 2'h0;
            aligned_q <= 1'b0;
        end
        else
        begin
            phase_q <= phase_d; // RQ10
            aligned_q <= aligned_q | align_rise;
        end
    end

    // Registered clamp control; held low until aligned or while disabled.
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            clamp_q <= 1'b0;
        else
            clamp_q <= dc_restore_enable && (aligned_q || align_rise) && (phase_d < `QACT_CLAMP_HIGH); // RQ10 RQ11 RQ8
    end

    // Clamp reaches only the 14-bit inputs.
    assign clamp_low_power_path = clamp_q; // RQ7
    assign clamp_hi_res_path = 1'b0; // RQ7

    // Output buffer between the pipeline and the serialiser.
    logic [63:0] fifo_in;
    wire fifo_push = pipe_q[LAT-1].valid;
    assign fifo_in = pipe_q[LAT-1].code;

    qact_fifo #(
        .WIDTH(64),
        .DEPTH(`QACT_FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .reset(reset),
        .in_valid(fifo_push),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out)
    );

    // A word lost to a full buffer is flagged until reset.
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            fifo_overflow <= 1'b0;
        else if (fifo_push && !fifo_in_ready)
            fifo_overflow <= 1'b1;
    end

    // Serialiser: 16 bits per channel lane, most significant bit first.
    qact_pkg::qact_ser_state_e ser_state_q;
    logic [63:0] shift_q;
    logic [3:0] bit_q;
    wire ser_last = (bit_q == 4'h0);
    wire ser_step = (ser_state_q == qact_pkg::QACT_SER_SHIFT) && serial_ready;
    wire ser_done = ser_step && ser_last;
    wire ser_load = fifo_out_valid && ((ser_state_q == qact_pkg::QACT_SER_IDLE) || ser_done);
    assign fifo_pop = ser_load;

    // Lane bits come from the top bit of each channel field.
    genvar ln;
    generate
        for (ln = 0; ln < `QACT_CHANNELS; ln++)
        begin : g_lane
            assign serial_data[ln] = shift_q[ln*16 + 15] && (ser_state_q == qact_pkg::QACT_SER_SHIFT); // RQ3
        end
    endgenerate
    assign serial_frame = (ser_state_q == qact_pkg::QACT_SER_SHIFT) && (bit_q == `QACT_SER_FIRST);

    // Serialiser state and shift register.
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            ser_state_q <= qact_pkg::QACT_SER_IDLE;
            shift_q <= 64'h0;
            bit_q <= 4'h0;
        end
        else
        begin
            case (ser_state_q)
                qact_pkg::QACT_SER_IDLE:
                begin
                    if (ser_load)
                    begin
                        ser_state_q <= qact_pkg::QACT_SER_SHIFT;
                        shift_q <= fifo_out;
                        bit_q <= `QACT_SER_FIRST;
                    end
                end
                qact_pkg::QACT_SER_SHIFT:
                begin
                    if (ser_load)
                    begin
                        shift_q <= fifo_out;
                        bit_q <= `QACT_SER_FIRST;
                    end
                    else if (ser_done)
                        ser_state_q <= qact_pkg::QACT_SER_IDLE;
                    else if (ser_step)
                    begin
                        shift_q <= {shift_q[62:0], 1'b0};
                        bit_q <= bit_q - 4'h1;
                    end
                end
                default:
                    ser_state_q <= qact_pkg::QACT_SER_IDLE;
            endcase
        end
    end
endmodule

`default_nettype wire

/* File: testbench/qact_top_properties.sv */
`timescale 1ns/100ps
`default_nettype none

// Port-level checks of the converter control block.
module qact_top_properties (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Inputs
    input wire logic [63:0] hi_res_input,
    input wire logic low_power_mode,
    input wire logic twos_comp_format,
    input wire logic dc_restore_enable,
    input wire logic frame_align_in,
    input wire logic serial_ready,
    // Outputs
    input wire logic hi_res_frontend_pd,
    input wire logic clamp_low_power_path,
    input wire logic clamp_hi_res_path,
    input wire qact_pkg::qact_stage_s pipe_word,
    input wire logic [3:0] serial_data,
    input wire logic serial_frame,
    input wire logic fifo_overflow
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    // Each assertion checks an output; those tied to a cause use the exact cycle count.
    a_frontend_pd_mode: assert property (hi_res_frontend_pd == low_power_mode)
        else $error("front end power-down does not follow the mode");
    a_hi_res_unclamped: assert property (!clamp_hi_res_path)
        else $error("clamp reached the high-resolution inputs");
    a_clamp_when_off: assert property ((!dc_restore_enable)[*2] |-> !clamp_low_power_path)
        else $error("clamp active while disabled");
    // A new alignment pulse may restart the pattern right after a high phase, so the pin must have been quiet.
    a_clamp_one_high: assert property ((!frame_align_in)[*4] ##0 clamp_low_power_path |->
        ##1 !clamp_low_power_path ##1 !clamp_low_power_path)
        else $error("clamp high phase not followed by two low cycles");
    a_clamp_repeats: assert property ((!frame_align_in)[*6] ##0 clamp_low_power_path && dc_restore_enable |->
        ##3 (clamp_low_power_path || !dc_restore_enable || !$past(dc_restore_enable)))
        else $error("clamp pattern did not repeat after three cycles");
    a_pipe_latency: assert property (pipe_word.valid && !pipe_word.low_power && !twos_comp_format
        && !$past(twos_comp_format, 16) |-> pipe_word.code == $past(hi_res_input, 16))
        else $error("output word is not the sample taken sixteen cycles earlier");
    a_mode_follows: assert property (pipe_word.valid |-> pipe_word.low_power == $past(low_power_mode, 16))
        else $error("word mode differs from the mode at capture");
    a_lp_left_just: assert property (pipe_word.valid && pipe_word.low_power |-> pipe_word.code[0][1:0] == 2'h0
        && pipe_word.code[3][1:0] == 2'h0)
        else $error("low-power code not left-justified");
    a_first_word: assert property ($fell(reset) |-> ##15 !pipe_word.valid ##1 pipe_word.valid)
        else $error("first word after reset not at sixteen cycles");
    a_bit_stands: assert property (serial_frame && !serial_ready |=> serial_frame && $stable(serial_data))
        else $error("serial bit moved while stalled");
    a_overflow_sticky: assert property (fifo_overflow |=> fifo_overflow)
        else $error("overflow flag dropped without reset");
endmodule

`default_nettype wire

/* File: testbench/qact_ccd_partner.sv */
`timescale 1ns/100ps
`default_nettype none

// Sensor timing source and serial word receiver.
module qact_ccd_partner (
    // Clock
    input wire logic clk_sys,
    // Serial receive side
    input wire logic [3:0] serial_data,
    input wire logic serial_frame,
    output logic serial_ready,
    // Sensor timing side
    output logic frame_align_in
);
    logic stall = 1'b0;
    logic slow = 1'b0;
    logic tog = 1'b0;
    logic got = 1'b0;
    logic [63:0] word = 64'h0;
    logic [15:0] sh [4];
    int cnt = 0;

    initial frame_align_in = 1'b0;

    // Ready drops every other cycle in slow mode to stall mid-word.
    assign serial_ready = !stall && !(slow && tog);
    always @(negedge clk_sys) tog <= !tog;

    // High-going alignment pulse, two cycles wide, at the sensor reset phase.
    task automatic sync_pulse();
        frame_align_in = 1'b1;
        fork
            begin
                repeat (2) @(negedge clk_sys);
                frame_align_in = 1'b0;
            end
        join_none
    endtask

    // Collects sixteen accepted bits per lane, most significant first.
    always @(posedge clk_sys)
    begin
        if (serial_ready && (serial_frame || cnt != 0))
        begin
            for (int n = 0; n < 4; n++)
                sh[n] = {sh[n][14:0], serial_data[n]};
            cnt = serial_frame ? 1 : cnt + 1;
            if (cnt == 16)
            begin
                word = {sh[3], sh[2], sh[1], sh[0]};
                got = 1'b1;
                cnt = 0;
            end
        end
    end
endmodule

`default_nettype wire

/* File: testbench/qact_top_tb.sv */
`timescale 1ns/100ps
`default_nettype none

module qact_top_tb;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [63:0] hi_res_input = 64'h8001_7ffe_c3a5_0f5a;
    logic [55:0] low_power_input = 56'h0;
    logic low_power_mode = 1'b0;
    logic twos_comp_format = 1'b0;
    logic dc_restore_enable = 1'b0;
    logic frame_align_in;
    logic hi_res_frontend_pd;
    logic clamp_low_power_path;
    logic clamp_hi_res_path;
    qact_pkg::qact_stage_s pipe_word;
    logic [3:0] serial_data;
    logic serial_frame;
    logic serial_ready;
    logic fifo_in_ready;
    logic fifo_overflow;
    int mismatches = 0;
    int n_compared = 0;

    // Converter clock, 50 ns period.
    always #25 clk_sys = ~clk_sys;

    qact_top DUT (.clk_sys, .reset, .hi_res_input, .low_power_input, .low_power_mode, .twos_comp_format,
        .dc_restore_enable, .frame_align_in, .hi_res_frontend_pd, .clamp_low_power_path, .clamp_hi_res_path,
        .pipe_word, .serial_data, .serial_frame, .serial_ready, .fifo_in_ready, .fifo_overflow);
    qact_ccd_partner P (.clk_sys, .serial_data, .serial_frame, .serial_ready, .frame_align_in);

    task automatic chk(input string what, input logic [65:0] exp, input logic [65:0] got);
        n_compared++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // A bounded wait that runs out counts as a mismatch.
    task automatic timeout_hit(input string what);
        mismatches++;
        $display("CHECK FAILED %s expected done seen timeout", what);
    endtask

    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // First word after reset, received with a stalling receiver.
    task automatic t_serial();
        int k;
        P.slow = 1'b1;
        for (k = 0; k < 100 && P.got !== 1'b1; k++) @(negedge clk_sys);
        if (P.got !== 1'b1)
            timeout_hit("serial word wait");
        chk("serial word", {2'h0, hi_res_input}, {2'h0, P.word});
        P.slow = 1'b0;
    endtask

    // Changing samples and modes, each word but the last sixteen checked sixteen cycles on.
    task automatic t_stream(input logic twos);
        qact_pkg::qact_stage_s q[$];
        qact_pkg::qact_stage_s e;
        logic [15:0] ii;
        for (int i = 0; i < 40; i++)
        begin
            @(negedge clk_sys);
            if (q.size() == 16)
                chk("pipe word", q.pop_front(), pipe_word);
            chk("front end off", {65'h0, low_power_mode}, {65'h0, hi_res_frontend_pd});
            ii = 16'(i * 37);
            twos_comp_format = twos;
            low_power_mode = ((i / 4) % 2) == 1;
            hi_res_input = {ii, ~ii, ii ^ 16'h5a5a, ii + 16'h8000};
            low_power_input = {ii[13:0], ~ii[13:0], ii[13:0] ^ 14'h2aaa, ii[13:0] ^ 14'h1234};
            e.valid = 1'b1;
            e.low_power = low_power_mode;
            for (int n = 0; n < 4; n++)
            begin
                e.code[n] = low_power_mode ? {low_power_input[14*n +: 14], 2'h0} : hi_res_input[16*n +: 16];
                e.code[n][15] ^= twos;
            end
            q.push_back(e);
        end
    endtask

    // Clamp pattern, restart at a new phase, and silence when disabled.
    task automatic t_clamp();
        int d;
        int k;
        dc_restore_enable = 1'b1;
        P.sync_pulse();
        for (d = 0; d < 12 && clamp_low_power_path !== 1'b1; d++) @(negedge clk_sys);
        if (clamp_low_power_path !== 1'b1)
            timeout_hit("clamp wait");
        for (k = 1; k <= 6; k++)
        begin
            @(negedge clk_sys);
            chk("clamp phase", {65'h0, k % 3 == 0}, {65'h0, clamp_low_power_path});
            chk("hi res clamp", 66'h0, {65'h0, clamp_hi_res_path});
        end
        repeat (((d + 1) % 3 != 0) ? 1 : 2) @(negedge clk_sys);
        P.sync_pulse();
        repeat (d) @(negedge clk_sys);
        chk("clamp restart", 66'h1, {65'h0, clamp_low_power_path});
        dc_restore_enable = 1'b0;
        P.sync_pulse();
        for (k = 0; k < 8; k++)
        begin
            @(negedge clk_sys);
            if (k > 0)
                chk("clamp off", 66'h0, {65'h0, clamp_low_power_path});
        end
    endtask

    // Mid-run reset clears the buffer, then a stalled receiver lets it fill until a word is dropped.
    task automatic t_overflow();
        int k;
        reset = 1'b1;
        P.stall = 1'b1;
        repeat (2) @(negedge clk_sys);
        chk("reset overflow", 66'h0, {65'h0, fifo_overflow});
        chk("reset fifo ready", 66'h1, {65'h0, fifo_in_ready});
        chk("reset pipe word", 66'h0, pipe_word);
        chk("reset serial data", 66'h0, {62'h0, serial_data});
        chk("reset clamp", 66'h0, {65'h0, clamp_low_power_path});
        reset = 1'b0;
        for (k = 0; k < 60 && fifo_in_ready !== 1'b0; k++) @(negedge clk_sys);
        if (fifo_in_ready !== 1'b0)
            timeout_hit("fifo fill wait");
        chk("fifo full", 66'h0, {65'h0, fifo_in_ready});
        chk("no early overflow", 66'h0, {65'h0, fifo_overflow});
        @(negedge clk_sys);
        chk("overflow", 66'h1, {65'h0, fifo_overflow});
        P.stall = 1'b0;
    endtask

    // Reset for 12 cycles, then the scenarios in turn.
    initial
    begin
        repeat (12) @(negedge clk_sys);
        reset = 1'b0;
        t_serial();
        t_stream(1'b0);
        t_stream(1'b1);
        t_clamp();
        t_overflow();
        final_report();
    end
endmodule

bind qact_top qact_top_properties u_props (.clk_sys, .reset, .hi_res_input, .low_power_mode, .twos_comp_format,
    .dc_restore_enable, .frame_align_in, .serial_ready, .hi_res_frontend_pd, .clamp_low_power_path,
    .clamp_hi_res_path, .pipe_word, .serial_data, .serial_frame, .fifo_overflow);

`default_nettype wire
